// *** hw/bfu_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bfu_defines.svh"

// Operation
// [RQ1] bit store copies register bit to T
// [RQ2] bit load writes T into register bit
// [RQ3] set sign flag forces S one
// [RQ4] clear sign flag forces S zero
// [RQ5] set/clear overflow drive V in one cycle
// [RQ6] set half carry forces H one
// [RQ7] clear half carry forces H zero
// [RQ8] sleep one cycle, flags kept, sleep pulse
// [RQ9] watchdog restart one cycle, flags kept, pulse
// [RQ10] break only with debug, flags kept
// [RQ11] every flag set/clear by index, one cycle
// [RQ12] arithmetic shift keeps sign; swap exchanges nibbles
module bfu_unit (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire bfu_pkg::bfu_op_t op_code,
  input wire logic [2:0] op_bit,
  input wire logic [7:0] op_data,
  input wire logic debug_enable,
  output logic [7:0] status_flags_register,
  output logic [7:0] result_data,
  output logic result_we,
  output logic sleep_req,
  output logic watchdog_restart_op,
  output logic break_req
);

  // ---------------------------------------------
  // flag state
  // ---------------------------------------------
  logic [7:0] flags_reg, flags_next;
  logic [7:0] res_reg, res_next;
  logic we_reg, we_next;
  logic slp_reg, slp_next;
  logic wdog_reg, wdog_next;
  logic brk_reg, brk_next;
  logic [7:0] shr_val;
  logic [7:0] bit_mask;

  // one-hot mask for a bit or flag index
  function automatic logic [7:0] bfu_onehot(input logic [2:0] idx);
    bfu_onehot = 8'h01 << idx;
  endfunction

  // true when the given operation is presented this cycle
  function automatic logic bfu_hit(
    input logic vld,
    input bfu_pkg::bfu_op_t code,
    input bfu_pkg::bfu_op_t want
  );
    bfu_hit = vld && (code == want);
  endfunction

  // sign is kept, lower bits move down
  assign shr_val = {op_data[7], op_data[7:1]};
  assign bit_mask = bfu_onehot(op_bit);

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    flags_next = flags_reg;
    res_next = res_reg;
    we_next = 1'b0;
    slp_next = 1'b0;
    wdog_next = 1'b0;
    brk_next = 1'b0;
    if (op_valid) begin
      case (op_code)
        bfu_pkg::BFU_OP_BIT_STORE: begin
          flags_next[`BFU_FLAG_T] = op_data[op_bit]; // RQ1
        end
        bfu_pkg::BFU_OP_BIT_LOAD: begin
          res_next = (op_data & ~bit_mask) |
                     ({8{flags_reg[`BFU_FLAG_T]}} & bit_mask); // RQ2
          we_next = 1'b1;
        end
        // covers S, V, H and all other flags by index
        bfu_pkg::BFU_OP_FSET: begin
          flags_next = flags_reg | bit_mask; // RQ3 RQ5 RQ6 RQ11
        end
        bfu_pkg::BFU_OP_FCLR: begin
          flags_next = flags_reg & ~bit_mask; // RQ4 RQ5 RQ7 RQ11
        end
        bfu_pkg::BFU_OP_ARITH_SHIFT: begin
          res_next = shr_val; // RQ12
          we_next = 1'b1;
          flags_next[`BFU_FLAG_C] = op_data[0];
          flags_next[`BFU_FLAG_Z] = (shr_val == 8'h00);
          flags_next[`BFU_FLAG_N] = shr_val[7];
          flags_next[`BFU_FLAG_V] = shr_val[7] ^ op_data[0];
          // sign test is N xor V, which reduces to old bit 0
          flags_next[`BFU_FLAG_S] = op_data[0];
        end
        bfu_pkg::BFU_OP_SWAP: begin
          res_next = {op_data[3:0], op_data[7:4]}; // RQ12
          we_next = 1'b1;
        end
        bfu_pkg::BFU_OP_SLEEP: begin
          slp_next = 1'b1; // RQ8
        end
        bfu_pkg::BFU_OP_WDOG: begin
          wdog_next = 1'b1; // RQ9
        end
        // ignored unless debugging is active
        bfu_pkg::BFU_OP_BREAK: begin
          brk_next = debug_enable; // RQ10
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_reg <= `BFU_FLAGS_RESET;
      res_reg <= 8'h00;
      we_reg <= 1'b0;
      slp_reg <= 1'b0;
      wdog_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      res_reg <= res_next;
      we_reg <= we_next;
      slp_reg <= slp_next;
      wdog_reg <= wdog_next;
      brk_reg <= brk_next;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign status_flags_register = flags_reg;
  assign result_data = res_reg;
  assign result_we = we_reg;
  assign sleep_req = slp_reg;
  assign watchdog_restart_op = wdog_reg;
  assign break_req = brk_reg;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence seq_sleep_issue;
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_SLEEP);
  endsequence
  sequence seq_wdog_issue;
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_WDOG);
  endsequence
  sequence seq_break_issue;
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_BREAK) && debug_enable;
  endsequence

  // pulse with flags untouched, then gone unless any op was valid the cycle before
  sequence seq_sleep_pulse;
    sleep_req && $stable(flags_reg) ##1
      (!sleep_req || $past(op_valid));
  endsequence
  sequence seq_wdog_pulse;
    watchdog_restart_op && $stable(flags_reg) ##1
      (!watchdog_restart_op || $past(op_valid));
  endsequence
  sequence seq_break_pulse;
    break_req && $stable(flags_reg) ##1
      (!break_req || $past(op_valid));
  endsequence

  // bit copy between register and copy flag
  bit_store_a: assert property ( // RQ1
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_BIT_STORE) |=>
      flags_reg[`BFU_FLAG_T] == $past(op_data[op_bit]) &&
      {flags_reg[7], flags_reg[5:0]} ==
      {$past(flags_reg[7]), $past(flags_reg[5:0])})
    else $error("bit store wrong");
  bit_load_a: assert property ( // RQ2
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_BIT_LOAD) |=>
      result_we && result_data[$past(op_bit)] == flags_reg[`BFU_FLAG_T] &&
      $stable(flags_reg))
    else $error("bit load wrong");
  load_keep_a: assert property ( // RQ2
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_BIT_LOAD) |=>
      (result_data & ~bfu_onehot($past(op_bit))) ==
      ($past(op_data) & ~bfu_onehot($past(op_bit))))
    else $error("bit load touched other bits");
  write_pulse_a: assert property ( // RQ2
    result_we |-> $past(op_valid) &&
      $past(op_code) inside {bfu_pkg::BFU_OP_BIT_LOAD,
      bfu_pkg::BFU_OP_ARITH_SHIFT, bfu_pkg::BFU_OP_SWAP})
    else $error("write without a writing op");

  // flag set and clear
  flag_set_a: assert property ( // RQ11
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_FSET) |=>
      flags_reg == ($past(flags_reg) | bfu_onehot($past(op_bit))))
    else $error("flag set wrong");
  flag_clear_a: assert property ( // RQ11
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_FCLR) |=>
      flags_reg == ($past(flags_reg) & ~bfu_onehot($past(op_bit))))
    else $error("flag clear wrong");
  sign_set_a: assert property ( // RQ3
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_FSET) &&
      op_bit == `BFU_FLAG_S |=> flags_reg[`BFU_FLAG_S] &&
      (flags_reg & ~bfu_onehot(`BFU_FLAG_S)) ==
      ($past(flags_reg) & ~bfu_onehot(`BFU_FLAG_S)))
    else $error("sign set wrong");
  sign_clear_a: assert property ( // RQ4
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_FCLR) &&
      op_bit == `BFU_FLAG_S |=> !flags_reg[`BFU_FLAG_S] &&
      (flags_reg & ~bfu_onehot(`BFU_FLAG_S)) ==
      ($past(flags_reg) & ~bfu_onehot(`BFU_FLAG_S)))
    else $error("sign clear wrong");
  ovf_set_a: assert property ( // RQ5
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_FSET) &&
      op_bit == `BFU_FLAG_V |=> flags_reg[`BFU_FLAG_V] &&
      (flags_reg & ~bfu_onehot(`BFU_FLAG_V)) ==
      ($past(flags_reg) & ~bfu_onehot(`BFU_FLAG_V)))
    else $error("overflow set wrong");
  ovf_clear_a: assert property ( // RQ5
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_FCLR) &&
      op_bit == `BFU_FLAG_V |=> !flags_reg[`BFU_FLAG_V] &&
      (flags_reg & ~bfu_onehot(`BFU_FLAG_V)) ==
      ($past(flags_reg) & ~bfu_onehot(`BFU_FLAG_V)))
    else $error("overflow clear wrong");
  half_set_a: assert property ( // RQ6
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_FSET) &&
      op_bit == `BFU_FLAG_H |=> flags_reg[`BFU_FLAG_H] &&
      (flags_reg & ~bfu_onehot(`BFU_FLAG_H)) ==
      ($past(flags_reg) & ~bfu_onehot(`BFU_FLAG_H)))
    else $error("half carry set wrong");
  half_clear_a: assert property ( // RQ7
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_FCLR) &&
      op_bit == `BFU_FLAG_H |=> !flags_reg[`BFU_FLAG_H] &&
      (flags_reg & ~bfu_onehot(`BFU_FLAG_H)) ==
      ($past(flags_reg) & ~bfu_onehot(`BFU_FLAG_H)))
    else $error("half carry clear wrong");

  // each flag moves only for its own index
  for (genvar g = 0; g < 8; g++) begin : g_flag
    flag_index_a: assert property ( // RQ11
      op_valid && op_bit != 3'(g) &&
      op_code inside {bfu_pkg::BFU_OP_FSET, bfu_pkg::BFU_OP_FCLR} |=>
        flags_reg[g] == $past(flags_reg[g]))
      else $error("flag index leaked");
  end

  // shift and swap
  shift_sign_a: assert property ( // RQ12
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_ARITH_SHIFT) |=>
      result_data[7:6] == {2{$past(op_data[7])}} &&
      flags_reg[`BFU_FLAG_C] == $past(op_data[0]))
    else $error("shift wrong");
  shift_data_a: assert property ( // RQ12
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_ARITH_SHIFT) |=>
      result_we && result_data == {$past(op_data[7]), $past(op_data[7:1])})
    else $error("shift data wrong");
  shift_flags_a: assert property ( // RQ12
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_ARITH_SHIFT) |=>
      flags_reg[`BFU_FLAG_Z] == (result_data == 8'h00) &&
      flags_reg[`BFU_FLAG_N] == result_data[7] &&
      flags_reg[`BFU_FLAG_V] == (result_data[7] ^ $past(op_data[0])) &&
      flags_reg[`BFU_FLAG_H] == $past(flags_reg[`BFU_FLAG_H]))
    else $error("shift flags wrong");
  swap_nib_a: assert property ( // RQ12
    bfu_hit(op_valid, op_code, bfu_pkg::BFU_OP_SWAP) |=>
      result_data == {$past(op_data[3:0]), $past(op_data[7:4])} &&
      $stable(flags_reg))
    else $error("swap wrong");

  // control operations
  sleep_pulse_a: assert property (seq_sleep_issue |=> seq_sleep_pulse) // RQ8
    else $error("sleep wrong");
  sleep_only_a: assert property ( // RQ8
    sleep_req |-> $past(op_valid) && $past(op_code) == bfu_pkg::BFU_OP_SLEEP)
    else $error("sleep without sleep op");
  wdog_pulse_a: assert property (seq_wdog_issue |=> seq_wdog_pulse) // RQ9
    else $error("watchdog restart wrong");
  wdog_only_a: assert property ( // RQ9
    watchdog_restart_op |-> $past(op_valid) &&
      $past(op_code) == bfu_pkg::BFU_OP_WDOG)
    else $error("watchdog restart without op");
  break_pulse_a: assert property (seq_break_issue |=> seq_break_pulse) // RQ10
    else $error("break not raised");
  break_gate_a: assert property ( // RQ10
    break_req |-> $past(debug_enable) && $past(op_valid) &&
      $past(op_code) == bfu_pkg::BFU_OP_BREAK)
    else $error("break without debug");
  ctl_flags_a: assert property ( // RQ8 RQ9 RQ10
    op_valid && op_code inside {bfu_pkg::BFU_OP_SLEEP,
      bfu_pkg::BFU_OP_WDOG, bfu_pkg::BFU_OP_BREAK} |=>
      $stable(flags_reg) && !result_we)
    else $error("control op touched state");

endmodule
`default_nettype wire

// *** hw/bfu_defines.svh ***
`ifndef BFU_DEFINES_SVH
`define BFU_DEFINES_SVH
// status flag positions
`define BFU_FLAG_C 3'd0
`define BFU_FLAG_Z 3'd1
`define BFU_FLAG_N 3'd2
`define BFU_FLAG_V 3'd3
`define BFU_FLAG_S 3'd4
`define BFU_FLAG_H 3'd5
`define BFU_FLAG_T 3'd6
`define BFU_FLAG_I 3'd7
`define BFU_FLAGS_RESET 8'h00
`define BFU_EXEC_CYCLES 1
`endif

// *** hw/bfu_pkg.sv ***
package bfu_pkg;
  typedef enum logic [4:0] {
    BFU_OP_NONE = 5'h00,
    BFU_OP_BIT_STORE = 5'h01,
    BFU_OP_BIT_LOAD = 5'h02,
    BFU_OP_FSET = 5'h03,
    BFU_OP_FCLR = 5'h04,
    BFU_OP_ARITH_SHIFT = 5'h05,
    BFU_OP_SWAP = 5'h06,
    BFU_OP_NOP = 5'h07,
    BFU_OP_SLEEP = 5'h08,
    BFU_OP_WDOG = 5'h09,
    BFU_OP_BREAK = 5'h0A
  } bfu_op_t;
endpackage

// *** test/bfu_rf_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// register file byte feeding the unit, takes writebacks
module bfu_rf_model (
  input wire logic mclk,
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic result_we,
  input wire logic [7:0] result_data,
  output logic [7:0] op_data
);
  always_ff @(posedge mclk) begin
    if (load) op_data <= load_val;
    else if (result_we) op_data <= result_data;
  end
endmodule
`default_nettype wire

// *** test/test_bit_and_flag_instruction_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_bit_and_flag_instruction_unit;
  logic mclk = 0, sys_rst = 1, op_valid = 0, debug_enable = 0, load = 1;
  logic result_we, sleep_req, watchdog_restart_op, break_req;
  bfu_pkg::bfu_op_t op_code = bfu_pkg::BFU_OP_NONE;
  logic [2:0] op_bit = 3'h0;
  logic [7:0] load_val = 8'h00, op_data, status_flags_register, result_data;
  int n_fail = 0, tests_run = 0, cyc = 0;
  bfu_unit dut_u (.mclk(mclk), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_code(op_code), .op_bit(op_bit), .op_data(op_data),
    .debug_enable(debug_enable),
    .status_flags_register(status_flags_register),
    .result_data(result_data), .result_we(result_we),
    .sleep_req(sleep_req), .watchdog_restart_op(watchdog_restart_op),
    .break_req(break_req));
  bfu_rf_model rf_u (.mclk(mclk), .load(load), .load_val(load_val),
    .result_we(result_we), .result_data(result_data), .op_data(op_data));
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 500) begin
      n_fail++;
      end_sim();
    end
  end
  task cmp(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task op(input bfu_pkg::bfu_op_t c, input logic [2:0] b);
    @(negedge mclk);
    op_valid = 1;
    op_code = c;
    op_bit = b;
    @(negedge mclk);
    op_valid = 0;
  endtask
  task ld(input logic [7:0] v);
    @(negedge mclk);
    load = 1;
    load_val = v;
    @(negedge mclk);
    load = 0;
  endtask
  task end_sim;
    $display("fails=%0d checks=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    sys_rst = 0;
    load = 0;
    for (int i = 0; i < 8; i++) begin
      op(bfu_pkg::BFU_OP_FSET, i[2:0]);
      cmp({8'hFF >> (7 - i), 8'h00}, {status_flags_register, result_data});
    end
    for (int i = 0; i < 8; i++) begin
      op(bfu_pkg::BFU_OP_FCLR, i[2:0]);
      cmp({8'hFE << i, 8'h00}, {status_flags_register, result_data});
    end
    ld(8'h08);
    op(bfu_pkg::BFU_OP_BIT_STORE, 3'h3);
    cmp(16'h4000, {status_flags_register, result_data});
    ld(8'hF0);
    op(bfu_pkg::BFU_OP_BIT_LOAD, 3'h0);
    cmp(16'h40F1, {status_flags_register, result_data});
    cmp(16'h0001, {15'h0000, result_we});
    @(negedge mclk);
    cmp(16'h0000, {15'h0000, result_we});
    op(bfu_pkg::BFU_OP_SWAP, 3'h0);
    cmp(16'h401F, {status_flags_register, result_data});
    ld(8'h81);
    op(bfu_pkg::BFU_OP_ARITH_SHIFT, 3'h0);
    cmp(16'h55C0, {status_flags_register, result_data});
    op(bfu_pkg::BFU_OP_SLEEP, 3'h0);
    cmp(16'h0001, {13'h0000, break_req, watchdog_restart_op, sleep_req});
    op(bfu_pkg::BFU_OP_WDOG, 3'h0);
    cmp(16'h0002, {13'h0000, break_req, watchdog_restart_op, sleep_req});
    op(bfu_pkg::BFU_OP_BREAK, 3'h0);
    cmp(16'h0000, {13'h0000, break_req, watchdog_restart_op, sleep_req});
    debug_enable = 1;
    op(bfu_pkg::BFU_OP_BREAK, 3'h0);
    cmp(16'h0004, {13'h0000, break_req, watchdog_restart_op, sleep_req});
    op(bfu_pkg::BFU_OP_NOP, 3'h0);
    cmp(16'h55C0, {status_flags_register, result_data});
    cmp(16'h0000, {13'h0000, break_req, watchdog_restart_op, sleep_req});
    end_sim();
  end
endmodule
`default_nettype wire
